// >>> scc_consts.svh
// register offsets, reset values and timing counts of the serial port control block
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_OFF_CTRL1 8'h00
`define SCC_OFF_CTRL2 8'h04
`define SCC_OFF_BAUD 8'h08
`define SCC_OFF_STAT 8'h0C
`define SCC_OFF_DATA 8'h10
`define SCC_CTRL1_RST 8'h04
`define SCC_CTRL2_RST 8'h00
`define SCC_BAUD_RST 8'h00
`define SCC_CTRL2_MASK 8'h1B
`define SCC_BAUD_MASK 8'h77
`define SCC_PIN_RST 4'hF
`define SCC_HALF_LAST 4'hF
`define SCC_BITS_FULL 4'h8
`define SCC_ONE11 11'h001
`define SCC_ZERO32 32'h0000_0000
`endif

// >>> scc_fifo.sv
// transmit byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign inReady = (cnt_q != FULL);
  assign outValid = (cnt_q != '0);
  assign outData = mem[rp_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    // a flush drops everything queued, an aborting disable relies on it
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// >>> scc_pkg.sv
// types shared by the serial port control block
package scc_pkg;
  typedef struct packed {
    logic receiveFaultIrqEnable;
    logic moduleEnable;
    logic transmitEmptyIrqEnable;
    logic roleSelect;
    logic clockIdleLevel;
    logic clockEdgePhase;
    logic selectOutputEnable;
    logic lowBitFirst;
  } scc_ctrl1_t;
  typedef struct packed {
    logic [2:0] rsvdHigh;
    logic faultDetectEnable;
    logic singleWireOutputEnable;
    logic rsvdMid;
    logic waitClockStop;
    logic singleWireSelect;
  } scc_ctrl2_t;
  typedef struct packed {
    logic serialClockPin;
    logic mosi;
    logic miso;
    logic ss;
  } scc_pin_in_t;
  typedef struct packed {
    logic sclkO;
    logic sclkE;
    logic mosiO;
    logic mosiE;
    logic misoO;
    logic misoE;
    logic ssO;
    logic ssE;
  } scc_pin_out_t;
  typedef enum logic {SCC_IDLE, SCC_RUN} scc_state_t;
endpackage

// >>> scc_serial_port.sv
// serial port control block: apb registers, pin multiplexing and byte shifter
//
// How it works
// - receive or fault flag raises interrupt when enabled
// - disabling aborts, flushes, clears receive, sets empty
// - transmit-empty flag raises interrupt when enabled
// - role bit: zero slave, one master
// - idle level bit sets serial clock idle
// - phase bit places first edge mid or start
// - bit order bit picks msb or lsb first
// - master without fault detect leaves select pin
// - master fault detect: input or automatic output
// - slave always uses select as low input
// - single wire bit shares one data pin
// - single wire output enable drives or releases
// - wait stop bit freezes module in wait
// - control two bits 7,6,5,2 read zero
// - disabled module releases all four pins
// - bit clock from prescaler and power-two divider
//
// Register access over APB and the register addresses are this design's own decisions.
`include "scc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module scc_serial_port #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire scc_pkg::scc_pin_in_t pinIn,
  output scc_pkg::scc_pin_out_t pinOut,
  // processor wait state and interrupt request
  input wire logic waitMode,
  output logic irqReq
);
  // ---------------------------------------------------------------
  // reset and pin synchronisers
  // ---------------------------------------------------------------
  logic rstMeta_q, rstn;
  scc_pkg::scc_pin_in_t pinMeta_q, pinSync_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstn <= rstMeta_q;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= `SCC_PIN_RST;
      pinSync_q <= `SCC_PIN_RST;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] shiftIn(input logic [7:0] sh, input logic b, input logic lsb);
    shiftIn = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  function automatic logic outBit(input logic [7:0] sh, input logic lsb);
    outBit = lsb ? sh[0] : sh[7];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  scc_pkg::scc_ctrl1_t c1_q, c1_d;
  scc_pkg::scc_ctrl2_t c2_q, c2_d;
  logic [7:0] baud_q, baud_d, rxData_q, rxData_d;
  logic [7:0] txSh_q, txSh_d, rxSh_q, rxSh_d;
  logic rf_q, rf_d, mf_q, mf_d;
  logic rfArm_q, rfArm_d, mfArm_q, mfArm_d, teArm_q, teArm_d;
  scc_pkg::scc_state_t st_q, st_d;
  logic [3:0] half_q, half_d, sBits_q, sBits_d;
  logic [10:0] div_q, div_d;
  logic sclkPrev_q, sclkPrev_d, ssPrev_q, ssPrev_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, irq_d;
  scc_pkg::scc_pin_out_t pin_d;

  logic fifoPush, fifoPop, fifoInReady, fifoOutValid;
  logic [7:0] fifoOutData;
  logic en, master, freeze, te, apbDone, faultIn, ssLow;
  logic [10:0] halfLen, halfMax;

  assign en = c1_q.moduleEnable;
  assign master = en & c1_q.roleSelect;
  assign te = fifoInReady;
  assign apbDone = psel & penable & pready;
  assign ssLow = !pinSync_q.ss;
  assign freeze = waitMode & c2_q.waitClockStop;
  // half a bit time is prescale times half the rate divisor
  assign halfLen = 11'({8'h00, baud_q[6:4]} + `SCC_ONE11) << baud_q[2:0];
  assign halfMax = halfLen - `SCC_ONE11;
  assign faultIn = master & c2_q.faultDetectEnable & !c1_q.selectOutputEnable;

  scc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) txFifo (
    .clk(core_clk),
    .rstn(rstn),
    .flush(!en),
    .inValid(fifoPush),
    .inData(pwdata[7:0]),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoPop)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic sIn, mIn, lead;
    sIn = c2_q.singleWireSelect ? pinSync_q.miso : pinSync_q.mosi;
    mIn = c2_q.singleWireSelect ? pinSync_q.mosi : pinSync_q.miso;
    lead = pinSync_q.serialClockPin != c1_q.clockIdleLevel;
    c1_d = c1_q;
    c2_d = c2_q;
    baud_d = baud_q;
    rxData_d = rxData_q;
    txSh_d = txSh_q;
    rxSh_d = rxSh_q;
    rf_d = rf_q;
    mf_d = mf_q;
    rfArm_d = rfArm_q;
    mfArm_d = mfArm_q;
    teArm_d = teArm_q;
    st_d = st_q;
    half_d = half_q;
    sBits_d = sBits_q;
    div_d = div_q;
    sclkPrev_d = pinSync_q.serialClockPin;
    ssPrev_d = pinSync_q.ss;
    prdata_d = prdata;
    pslverr_d = pslverr;
    pready_d = 1'b0;
    fifoPush = 1'b0;
    fifoPop = 1'b0;

    // bus access: answer one cycle into the access phase, later for an armed data write while the queue is full
    if (psel && penable && !pready) begin
      pslverr_d = 1'b0;
      prdata_d = `SCC_ZERO32;
      pready_d = !(pwrite && paddr == `SCC_OFF_DATA && teArm_q && !fifoInReady);
      unique case (paddr)
        `SCC_OFF_CTRL1: prdata_d[7:0] = c1_q;
        `SCC_OFF_CTRL2: prdata_d[7:0] = c2_q & `SCC_CTRL2_MASK;
        `SCC_OFF_BAUD: prdata_d[7:0] = baud_q;
        `SCC_OFF_STAT: prdata_d[7:0] = {rf_q, 1'b0, te, mf_q, 4'h0};
        `SCC_OFF_DATA: prdata_d[7:0] = rxData_q;
        default: pslverr_d = 1'b1;
      endcase
    end
    if (apbDone && pwrite) begin
      unique case (paddr)
        `SCC_OFF_CTRL1: begin
          c1_d = pwdata[7:0];
          if (mfArm_q) begin
            mf_d = 1'b0;
            mfArm_d = 1'b0;
          end
        end
        `SCC_OFF_CTRL2: c2_d = pwdata[7:0] & `SCC_CTRL2_MASK;
        `SCC_OFF_BAUD: baud_d = pwdata[7:0] & `SCC_BAUD_MASK;
        `SCC_OFF_DATA: begin
          // a data write without a prior status read is ignored
          fifoPush = teArm_q & en;
          teArm_d = 1'b0;
        end
        default: ;
      endcase
    end
    if (apbDone && !pwrite) begin
      if (paddr == `SCC_OFF_STAT) begin
        rfArm_d = rf_q;
        mfArm_d = mf_q;
        teArm_d = te;
      end
      if (paddr == `SCC_OFF_DATA && rfArm_q) begin
        rf_d = 1'b0;
        rfArm_d = 1'b0;
      end
    end

    // master engine: sixteen half bit times per byte
    if (!master) begin
      st_d = scc_pkg::SCC_IDLE;
    end else if (!freeze) begin
      unique case (st_q)
        scc_pkg::SCC_IDLE: begin
          if (fifoOutValid) begin
            fifoPop = 1'b1;
            txSh_d = fifoOutData;
            half_d = '0;
            div_d = '0;
            st_d = scc_pkg::SCC_RUN;
          end
        end
        scc_pkg::SCC_RUN: begin
          if (div_q == halfMax) begin
            div_d = '0;
            if (half_q == `SCC_HALF_LAST) begin
              rxData_d = rxSh_q;
              rf_d = 1'b1;
              st_d = scc_pkg::SCC_IDLE;
            end else begin
              half_d = half_q + 1'b1;
              if (!half_q[0]) begin
                rxSh_d = shiftIn(rxSh_q, mIn, c1_q.lowBitFirst);
              end else begin
                txSh_d = shiftIn(txSh_q, 1'b0, c1_q.lowBitFirst);
              end
            end
          end else begin
            div_d = div_q + `SCC_ONE11;
          end
        end
      endcase
    end

    // slave engine: follows the synchronised clock while selected
    if (en && !c1_q.roleSelect && !freeze) begin
      if (!ssLow) begin
        sBits_d = '0;
      end else if (ssPrev_q) begin
        if (fifoOutValid) begin
          fifoPop = 1'b1;
          txSh_d = fifoOutData;
        end
      end else if (pinSync_q.serialClockPin != sclkPrev_q) begin
        if (lead == c1_q.clockEdgePhase) begin
          if (sBits_q != '0) begin
            txSh_d = shiftIn(txSh_q, 1'b0, c1_q.lowBitFirst);
          end
        end else begin
          rxSh_d = shiftIn(rxSh_q, sIn, c1_q.lowBitFirst);
          sBits_d = sBits_q + 1'b1;
          if (sBits_q + 1'b1 == `SCC_BITS_FULL) begin
            sBits_d = '0;
            rxData_d = shiftIn(rxSh_q, sIn, c1_q.lowBitFirst);
            rf_d = 1'b1;
            if (fifoOutValid) begin
              fifoPop = 1'b1;
              txSh_d = fifoOutData;
            end
          end
        end
      end
    end

    // a low select while detecting faults ends master operation
    if (faultIn && ssLow) begin
      mf_d = 1'b1;
      c1_d.roleSelect = 1'b0;
      st_d = scc_pkg::SCC_IDLE;
    end

    if (!en) begin
      st_d = scc_pkg::SCC_IDLE;
      rf_d = 1'b0;
      rfArm_d = 1'b0;
      sBits_d = '0;
    end

    // pin multiplexing, registered below so every pin leaves a flop
    pin_d = '0;
    pin_d.sclkE = master;
    pin_d.sclkO = c1_q.clockIdleLevel ^ ((st_q == scc_pkg::SCC_RUN) & (half_q[0] ^ c1_q.clockEdgePhase));
    pin_d.mosiO = outBit(txSh_q, c1_q.lowBitFirst);
    pin_d.misoO = outBit(txSh_q, c1_q.lowBitFirst);
    pin_d.mosiE = master & (!c2_q.singleWireSelect | c2_q.singleWireOutputEnable);
    pin_d.misoE = en & !c1_q.roleSelect & ssLow & (!c2_q.singleWireSelect | c2_q.singleWireOutputEnable);
    pin_d.ssE = master & c2_q.faultDetectEnable & c1_q.selectOutputEnable;
    pin_d.ssO = (st_q != scc_pkg::SCC_RUN);
    if (!en) begin
      pin_d = '0;
    end
    irq_d = (c1_q.receiveFaultIrqEnable & (rf_q | mf_q)) | (c1_q.transmitEmptyIrqEnable & te);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c1_q <= `SCC_CTRL1_RST;
      c2_q <= `SCC_CTRL2_RST;
      baud_q <= `SCC_BAUD_RST;
      rxData_q <= '0;
      txSh_q <= '0;
      rxSh_q <= '0;
      rf_q <= 1'b0;
      mf_q <= 1'b0;
      rfArm_q <= 1'b0;
      mfArm_q <= 1'b0;
      teArm_q <= 1'b0;
      st_q <= scc_pkg::SCC_IDLE;
      half_q <= '0;
      sBits_q <= '0;
      div_q <= '0;
      sclkPrev_q <= 1'b1;
      ssPrev_q <= 1'b1;
      prdata <= `SCC_ZERO32;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pinOut <= '0;
      irqReq <= 1'b0;
    end else begin
      c1_q <= c1_d;
      c2_q <= c2_d;
      baud_q <= baud_d;
      rxData_q <= rxData_d;
      txSh_q <= txSh_d;
      rxSh_q <= rxSh_d;
      rf_q <= rf_d;
      mf_q <= mf_d;
      rfArm_q <= rfArm_d;
      mfArm_q <= mfArm_d;
      teArm_q <= teArm_d;
      st_q <= st_d;
      half_q <= half_d;
      sBits_q <= sBits_d;
      div_q <= div_d;
      sclkPrev_q <= sclkPrev_d;
      ssPrev_q <= ssPrev_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      pinOut <= pin_d;
      irqReq <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence seqStart;
    master && st_q == scc_pkg::SCC_IDLE && fifoOutValid && !freeze && !(faultIn && ssLow);
  endsequence
  sequence seqFirstHalf;
    st_q == scc_pkg::SCC_RUN && half_q == '0;
  endsequence

  AST_IRQ_RX: assert property (c1_q.receiveFaultIrqEnable && (rf_q || mf_q) |=> irqReq)
    else $error("receive or fault interrupt missing");
  AST_DISABLE: assert property (!en |=> !rf_q && st_q == scc_pkg::SCC_IDLE ##1 te)
    else $error("disable did not clear state");
  AST_IRQ_OFF: assert property (!c1_q.receiveFaultIrqEnable && !c1_q.transmitEmptyIrqEnable |=> !irqReq)
    else $error("interrupt raised while both enables clear");
  AST_IRQ_TX: assert property (c1_q.transmitEmptyIrqEnable && te |=> irqReq)
    else $error("transmit empty interrupt missing");
  AST_SLAVE_CLK: assert property (en && !c1_q.roleSelect |=> !pinOut.sclkE)
    else $error("slave drives serial clock");
  AST_IDLE_LEVEL: assert property (master && st_q == scc_pkg::SCC_IDLE |=> pinOut.sclkO == $past(c1_q.clockIdleLevel))
    else $error("serial clock not at idle level");
  AST_PHASE: assert property (seqStart ##1 seqFirstHalf |=>
    pinOut.sclkO == $past(c1_q.clockIdleLevel ^ c1_q.clockEdgePhase, 2))
    else $error("first clock edge misplaced");
  AST_SS_GPIO: assert property (master && !c2_q.faultDetectEnable |=> !pinOut.ssE)
    else $error("select pin driven without fault detect");
  AST_SS_AUTO: assert property (seqStart ##1 seqFirstHalf ##1
    (st_q == scc_pkg::SCC_RUN && pinOut.ssE) |-> !pinOut.ssO)
    else $error("automatic select not low during byte");
  AST_FAULT: assert property (faultIn && ssLow |=> mf_q && !c1_q.roleSelect ##1 !pinOut.sclkE)
    else $error("mode fault not taken");
  AST_SW_OE: assert property (master && c2_q.singleWireSelect && !c2_q.singleWireOutputEnable |=> !pinOut.mosiE)
    else $error("single wire driver on while disabled");
  AST_WAIT: assert property (freeze && st_q == scc_pkg::SCC_RUN && master |=> $stable(half_q) && $stable(div_q))
    else $error("engine ran during wait stop");
  AST_RSVD: assert property (psel && penable && pready && !pwrite && paddr == `SCC_OFF_CTRL2 |-> prdata[7:5] == 3'h0 && !prdata[2])
    else $error("reserved control bits read non zero");
  AST_PINS_OFF: assert property (!en |=> pinOut == '0)
    else $error("pins driven while disabled");
endmodule
`default_nettype wire

// >>> scc_slave_model.sv
// behavioural spi slave peripheral on the far side of the serial port
`timescale 1ns/1ps
`default_nettype none
module scc_slave_model #(
  parameter logic [7:0] REPLY = 8'hC5
) (
  // clock
  input wire logic clk,
  // link pins and format
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss,
  input wire logic clock_idle_level,
  input wire logic clock_edge_phase,
  output logic miso,
  // captured byte and bit spacing
  output logic [7:0] capByte,
  output logic capStrobe,
  output logic [15:0] edgeGap
);
  logic prevSclk = 1'b0;
  logic [2:0] cnt = 3'h0;
  logic [6:0] sh = 7'h00;
  logic [15:0] gapCnt = 16'h0000;
  logic sampleEdge;
  initial begin
    miso = 1'b0;
    capByte = 8'h00;
    capStrobe = 1'b0;
    edgeGap = 16'h0000;
  end
  // leading edge samples in phase 0, trailing edge in phase 1
  assign sampleEdge = !ss && (sclk != prevSclk) && (sclk == !(clock_idle_level ^ clock_edge_phase));
  always @(posedge clk) begin
    prevSclk <= sclk;
    capStrobe <= 1'b0;
    gapCnt <= gapCnt + 16'h0001;
    if (ss) begin
      cnt <= 3'h0;
      // deselected: line shows a changing pattern, never the last bit
      miso <= ~miso;
    end else begin
      miso <= REPLY[3'h7 - cnt];
      if (sampleEdge) begin
        sh <= {sh[5:0], mosi};
        cnt <= cnt + 3'h1;
        edgeGap <= gapCnt;
        gapCnt <= 16'h0001;
        if (cnt == 3'h7) begin
          capByte <= {sh, mosi};
          capStrobe <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the serial port control block
`include "scc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, waitMode, irqReq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, patt, tbSs, tbSclk, tbMosi, clock_idle_level, clock_edge_phase, miso, sclkW, mosiW, misoW, ssW, capStrobe;
  logic [7:0] capByte, tbRx;
  logic [15:0] edgeGap;
  logic [7:0] capQ[$];
  scc_pkg::scc_pin_in_t pinIn;
  scc_pkg::scc_pin_out_t pinOut;
  int failCount, totalChecks, n;
  // released clock and mosi lines show a toggling pattern unless the bench acts as master
  assign sclkW = pinOut.sclkE ? pinOut.sclkO : (tbSs ? patt : tbSclk);
  assign mosiW = pinOut.mosiE ? pinOut.mosiO : (tbSs ? patt : tbMosi);
  assign misoW = pinOut.misoE ? pinOut.misoO : miso;
  assign ssW = pinOut.ssE ? pinOut.ssO : tbSs;
  assign pinIn = {sclkW, mosiW, misoW, ssW};
  scc_serial_port #(.FIFO_DEPTH(8)) u_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .waitMode(waitMode), .irqReq(irqReq));
  scc_slave_model u_peer (.clk(core_clk), .sclk(sclkW), .mosi(mosiW), .ss(ssW), .clock_idle_level(clock_idle_level), .clock_edge_phase(clock_edge_phase),
    .miso(miso), .capByte(capByte), .capStrobe(capStrobe), .edgeGap(edgeGap));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    patt <= ~patt;
    if (capStrobe === 1'b1) capQ.push_back(capByte);
  end
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    totalChecks++;
    if (act !== exp) begin
      failCount++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) failCount++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(exp, r);
  endtask
  task automatic pe(input logic [3:0] exp);
    repeat (3) @(posedge core_clk);
    chk(exp, {pinOut.sclkE, pinOut.mosiE, pinOut.misoE, pinOut.ssE});
  endtask
  // a data write counts only after a status read
  task automatic send(input logic [7:0] b);
    apb(1'b0, `SCC_OFF_STAT, 32'h0000_0000);
    w(`SCC_OFF_DATA, {24'h00_0000, b});
  endtask
  task automatic waitRf;
    int k;
    k = 0;
    do begin
      apb(1'b0, `SCC_OFF_STAT, 32'h0000_0000);
      k++;
    end while (r[7] !== 1'b1 && k < 400);
    if (k >= 400) failCount++;
  endtask
  // bench as master, format with phase one: drive on leading edge, sample on trailing edge
  task automatic slaveXfer(input logic [7:0] b);
    tbSs <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int j = 7; j >= 0; j--) begin
      tbSclk <= 1'b1;
      tbMosi <= b[j];
      repeat (8) @(posedge core_clk);
      tbSclk <= 1'b0;
      tbRx <= {tbRx[6:0], misoW};
      repeat (8) @(posedge core_clk);
    end
    tbSs <= 1'b1;
  endtask
  task automatic finalReport;
    if (failCount == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    failCount++;
    finalReport;
  end
  // ----
  // tests
  // ----
  initial begin
    {resetn, psel, penable, pwrite, waitMode, patt, clock_idle_level, clock_edge_phase, tbSclk, tbMosi} = 10'h000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tbSs = 1'b1;
    failCount = 0;
    totalChecks = 0;
    repeat (6) @(posedge core_clk);
    chk(8'h00, pinOut);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc(`SCC_OFF_CTRL1, 32'h0000_0004);
    rc(`SCC_OFF_CTRL2, 32'h0000_0000);
    rc(`SCC_OFF_STAT, 32'h0000_0020);
    pe(4'h0);
    w(`SCC_OFF_CTRL2, 32'h0000_00FF);
    rc(`SCC_OFF_CTRL2, 32'h0000_001B);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0000_0000, e});
    w(`SCC_OFF_CTRL2, 32'h0000_0012);
    w(`SCC_OFF_CTRL1, 32'h0000_0046);
    pe(4'h0);
    w(`SCC_OFF_CTRL2, 32'h0000_0000);
    w(`SCC_OFF_CTRL1, 32'h0000_0056);
    pe(4'hC);
    w(`SCC_OFF_CTRL2, 32'h0000_0001);
    pe(4'h8);
    w(`SCC_OFF_CTRL2, 32'h0000_0009);
    pe(4'hC);
    w(`SCC_OFF_CTRL2, 32'h0000_0018);
    pe(4'hD);
    w(`SCC_OFF_CTRL2, 32'h0000_0010);
    w(`SCC_OFF_BAUD, 32'h0000_0031);
    for (int m = 0; m < 4; m++) begin
      clock_idle_level <= m[1];
      clock_edge_phase <= m[0];
      w(`SCC_OFF_CTRL1, {24'h00_0000, 4'h5, m[1:0], 2'h2});
      send(8'h96 + m[7:0]);
      waitRf;
      chk(8'h96 + m[7:0], capByte);
      chk(16'h0010, edgeGap);
      chk({m[1], 2'h3}, {pinOut.sclkO, pinOut.ssO, pinOut.ssE});
      chk(1'b0, irqReq);
      rc(`SCC_OFF_DATA, 32'h0000_00C5);
    end
    clock_idle_level <= 1'b0;
    clock_edge_phase <= 1'b0;
    w(`SCC_OFF_CTRL1, 32'h0000_00D3);
    send(8'h1E);
    waitRf;
    chk(8'h78, capByte);
    chk(1'b1, irqReq);
    rc(`SCC_OFF_DATA, 32'h0000_00A3);
    repeat (2) @(posedge core_clk);
    chk(1'b0, irqReq);
    w(`SCC_OFF_CTRL1, 32'h0000_0072);
    repeat (2) @(posedge core_clk);
    chk(1'b1, irqReq);
    // abort mid-transfer with a byte queued and receive full set
    w(`SCC_OFF_CTRL1, 32'h0000_0052);
    send(8'h55);
    waitRf;
    send(8'hAA);
    send(8'h33);
    w(`SCC_OFF_CTRL1, 32'h0000_0012);
    rc(`SCC_OFF_STAT, 32'h0000_0020);
    pe(4'h0);
    w(`SCC_OFF_CTRL1, 32'h0000_0052);
    repeat (400) @(posedge core_clk);
    rc(`SCC_OFF_STAT, 32'h0000_0020);
    w(`SCC_OFF_CTRL2, 32'h0000_0012);
    waitMode <= 1'b1;
    send(8'h3C);
    repeat (400) @(posedge core_clk);
    rc(`SCC_OFF_STAT, 32'h0000_0020);
    waitMode <= 1'b0;
    waitRf;
    chk(8'h3C, capByte);
    rc(`SCC_OFF_DATA, 32'h0000_00C5);
    w(`SCC_OFF_CTRL2, 32'h0000_0010);
    waitMode <= 1'b1;
    send(8'hC3);
    waitRf;
    chk(8'hC3, capByte);
    waitMode <= 1'b0;
    rc(`SCC_OFF_DATA, 32'h0000_00C5);
    // slow link so the queue fills before it drains
    w(`SCC_OFF_BAUD, 32'h0000_0034);
    capQ.delete();
    n = 0;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, `SCC_OFF_STAT, 32'h0000_0000);
      if (r[5] !== 1'b1) break;
      w(`SCC_OFF_DATA, {24'h00_0000, 8'h30 + 8'(i)});
      n++;
    end
    chk(32'h0000_0009, n);
    n = 0;
    while (capQ.size() < 9 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    for (int i = 0; i < 9; i++) chk(8'h30 + 8'(i), capQ[i]);
    chk(16'h0080, edgeGap);
    // let the last byte finish so its receive flag is cleared below
    repeat (100) @(posedge core_clk);
    apb(1'b0, `SCC_OFF_STAT, 32'h0000_0000);
    apb(1'b0, `SCC_OFF_DATA, 32'h0000_0000);
    w(`SCC_OFF_CTRL1, 32'h0000_00D4);
    pe(4'hC);
    tbSs <= 1'b0;
    repeat (8) @(posedge core_clk);
    tbSs <= 1'b1;
    rc(`SCC_OFF_STAT, 32'h0000_0030);
    chk(1'b1, irqReq);
    rc(`SCC_OFF_CTRL1, 32'h0000_00C4);
    // block answers as a slave; this write also clears the armed fault flag
    w(`SCC_OFF_CTRL1, 32'h0000_0044);
    send(8'h5A);
    slaveXfer(8'hA5);
    rc(`SCC_OFF_STAT, 32'h0000_00A0);
    rc(`SCC_OFF_DATA, 32'h0000_00A5);
    chk(8'h5A, tbRx);
    finalReport;
  end
endmodule
`default_nettype wire
